// ===== logic/bdc_cfg.svh
`ifndef BDC_CFG_SVH
`define BDC_CFG_SVH
// Overview of operation
// - Direction 01 mem-to-periph, 10 periph-to-mem, 11 periph-to-periph.
// - Destination steps up 01, down 10, fixed 11.
// - 28-bit initial/current destination address, reset zero.
// - Count bits 31:30 select request source.
// - Fixed handshake, unit transfer fields read 00/01.
// - Interrupt: 00 none, 10 per unit, 11 terminal.
// - Auto-reload reloads at zero, keeps enable set.
// - After reload, wait for start or request.
// - Enabled channel serves gated requests or start.
// - Enable clear blocks new units; a unit in flight completes.
// - Cancel aborts transfer and clears enable.
// - Terminal count clears enable unless auto-reload.
// - Count drops 1, 2 or 4 per unit.
// - 20-bit byte count, reset zero.
// - Size 00 byte, 01 half, 10 word.
// - Command 11 cancels; command field self-clears.
// - Request gate passes requests only at 00.

// -----------------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------------
`define BDC_OFF_CTRL 8'h00
`define BDC_OFF_ISRC 8'h04
`define BDC_OFF_IDES 8'h08
`define BDC_OFF_INITIAL_COUNT 8'h0c
`define BDC_OFF_CSRC 8'h10
`define BDC_OFF_CDES 8'h14
`define BDC_OFF_CURRENT_COUNT 8'h18

// -----------------------------------------------------------------------
// Field positions and codes
// -----------------------------------------------------------------------
`define BDC_HI_MSB 31
`define BDC_HI_LSB 30
`define BDC_MID_MSB 29
`define BDC_MID_LSB 28
`define BDC_ADDR_MSB 27
`define BDC_ADDR_W 28
`define BDC_CNT_MSB 19
`define BDC_CNT_W 20
`define BDC_INTM_MSB 23
`define BDC_INTM_LSB 22
`define BDC_AR_BIT 21
`define BDC_EN_BIT 20
`define BDC_GATE_MSB 3
`define BDC_GATE_LSB 2
`define BDC_CMD_MSB 1
`define BDC_CMD_LSB 0
`define BDC_FIXED_MODES 6'h04
`define BDC_CMD_START 2'h1
`define BDC_CMD_CANCEL 2'h3
`define BDC_GATE_OPEN 2'h0
`define BDC_DIR_RESERVED 2'h0
`define BDC_STEP_INC 2'h1
`define BDC_STEP_DEC 2'h2
`define BDC_SIZE_BYTE 2'h0
`define BDC_SIZE_HALF 2'h1
`define BDC_INT_UNIT 2'h2
`define BDC_INT_TC 2'h3
`define BDC_STAT_READY 2'h0
`define BDC_STAT_BUSY 2'h1
`define BDC_REQ_W 4

// -----------------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------------
`define BDC_RST_FIELD2 2'h0
`define BDC_RST_ADDR 28'h0000000
`define BDC_RST_CNT 20'h00000
`endif

// ===== logic/bdc_pkg.sv
`default_nettype none
`include "bdc_cfg.svh"
package bdc_pkg;
	typedef enum logic [1:0] {
		BDC_IDLE = 2'h0,
		BDC_BUSY = 2'h1
	} bdc_state_e;

	typedef struct packed {
		bdc_state_e state;
		logic [1:0] gate;
		logic [1:0] dest_dir;
		logic [1:0] dest_step;
		logic [27:0] init_dest;
		logic [27:0] cur_dest;
		logic [1:0] size;
		logic [1:0] src_step;
		logic [27:0] init_src;
		logic [27:0] cur_src;
		logic [1:0] req_src;
		logic [1:0] int_mode;
		logic auto_reload;
		logic en;
		logic [19:0] init_count;
		logic [19:0] cur_count;
		logic run;
		logic req_pend;
		logic [3:0] req_s1;
		logic [3:0] req_s2;
		logic req_old;
		logic [31:0] rdata;
		logic irq;
		logic xfer_valid;
	} bdc_state_s;
endpackage : bdc_pkg
`default_nettype wire

// ===== logic/bdc_step_if.sv
`default_nettype none
interface bdc_step_if;
	logic [1:0] size;
	logic [1:0] dest_step;
	logic [1:0] src_step;
	logic [27:0] dest_addr;
	logic [27:0] src_addr;
	logic [19:0] count;
	logic [27:0] next_dest;
	logic [27:0] next_src;
	logic [19:0] next_count;
	logic terminal;

	modport user (output size, dest_step, src_step, dest_addr, src_addr,
		count, input next_dest, next_src, next_count, terminal);
	modport calc (input size, dest_step, src_step, dest_addr, src_addr,
		count, output next_dest, next_src, next_count, terminal);
endinterface : bdc_step_if
`default_nettype wire

// ===== logic/bdc_step.sv
`default_nettype none
`include "bdc_cfg.svh"
module bdc_step (
	bdc_step_if.calc st
);
	logic [19:0] bytes;

	// A size of 11 is unused; it steps as a word so the channel never stalls.
	always_comb begin
		case (st.size)
			`BDC_SIZE_BYTE: bytes = 20'h00001;
			`BDC_SIZE_HALF: bytes = 20'h00002;
			default: bytes = 20'h00004;
		endcase
	end

	// A count that is not a multiple of the size ends at zero, not wrapping.
	assign st.next_count = (st.count > bytes) ? st.count - bytes
		: `BDC_RST_CNT;
	assign st.terminal = (st.next_count == `BDC_RST_CNT);

	function automatic logic [27:0] step_addr(input logic [27:0] a,
		input logic [1:0] mode, input logic [27:0] b);
		case (mode)
			`BDC_STEP_INC: step_addr = a + b;
			`BDC_STEP_DEC: step_addr = a - b;
			default: step_addr = a;
		endcase
	endfunction

	assign st.next_dest = step_addr(st.dest_addr, st.dest_step,
		{8'h00, bytes});
	assign st.next_src = step_addr(st.src_addr, st.src_step, {8'h00, bytes});
endmodule // bdc_step
`default_nettype wire

// ===== logic/bdc_channel.sv
// Implementation choices: the placing of the registers and strobed register access.
`default_nettype none
`include "bdc_cfg.svh"
module bdc_channel (
	input wire logic clock,
	input wire logic reset,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	input wire logic [3:0] dma_req,
	output logic xfer_valid,
	input wire logic xfer_done,
	output logic [1:0] xfer_dir,
	output logic [1:0] xfer_size,
	output logic [27:0] xfer_src,
	output logic [27:0] xfer_dest,
	output logic irq_pulse
);
	bdc_pkg::bdc_state_s s;
	bdc_pkg::bdc_state_s next_s;
	bdc_step_if st ();

	logic [1:0] cmd;
	logic wr_ctrl;
	logic wr_isrc;
	logic wr_ides;
	logic wr_initial_count;
	logic cancel;
	logic start;
	logic req_now;
	logic req_edge;
	logic [1:0] status;
	logic [31:0] cnt_upper;

	bdc_step i_bdc_step (
		.st(st)
	);

	assign st.size = s.size;
	assign st.dest_step = s.dest_step;
	assign st.src_step = s.src_step;
	assign st.dest_addr = s.cur_dest;
	assign st.src_addr = s.cur_src;
	assign st.count = s.cur_count;

	// -------------------------------------------------------------------
	// Register decode
	// -------------------------------------------------------------------
	assign wr_ctrl = reg_write && (reg_addr == `BDC_OFF_CTRL);
	assign wr_isrc = reg_write && (reg_addr == `BDC_OFF_ISRC);
	assign wr_ides = reg_write && (reg_addr == `BDC_OFF_IDES);
	assign wr_initial_count = reg_write && (reg_addr == `BDC_OFF_INITIAL_COUNT);
	assign cmd = reg_wdata[`BDC_CMD_MSB:`BDC_CMD_LSB];
	assign cancel = wr_ctrl && (cmd == `BDC_CMD_CANCEL);
	assign start = wr_ctrl && (cmd == `BDC_CMD_START);

	// Only the selected source is watched; selection 00 names no source.
	assign req_now = (s.req_src != 2'h0) && s.req_s2[s.req_src];
	assign req_edge = req_now && !s.req_old;

	assign status = (s.state == bdc_pkg::BDC_BUSY) ? `BDC_STAT_BUSY
		: `BDC_STAT_READY;
	assign cnt_upper = {s.req_src, `BDC_FIXED_MODES, s.int_mode,
		s.auto_reload, s.en, 20'h00000};

	// -------------------------------------------------------------------
	// Next state
	// -------------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.irq = 1'b0;
		next_s.rdata = 32'h00000000;
		next_s.req_s1 = dma_req;
		next_s.req_s2 = s.req_s1;
		next_s.req_old = req_now;

		// A request edge in the cycle it is consumed stays pending.
		if (req_edge) begin
			next_s.req_pend = 1'b1;
		end

		if (wr_ctrl) begin
			next_s.gate = reg_wdata[`BDC_GATE_MSB:`BDC_GATE_LSB];
		end
		if (wr_isrc) begin
			next_s.size = reg_wdata[`BDC_HI_MSB:`BDC_HI_LSB];
			next_s.src_step = reg_wdata[`BDC_MID_MSB:`BDC_MID_LSB];
			next_s.init_src = reg_wdata[`BDC_ADDR_MSB:0];
		end
		if (wr_ides) begin
			next_s.dest_dir = reg_wdata[`BDC_HI_MSB:`BDC_HI_LSB];
			next_s.dest_step = reg_wdata[`BDC_MID_MSB:`BDC_MID_LSB];
			next_s.init_dest = reg_wdata[`BDC_ADDR_MSB:0];
		end
		if (wr_initial_count) begin
			next_s.req_src = reg_wdata[`BDC_HI_MSB:`BDC_HI_LSB];
			next_s.int_mode = reg_wdata[`BDC_INTM_MSB:`BDC_INTM_LSB];
			next_s.auto_reload = reg_wdata[`BDC_AR_BIT];
			next_s.en = reg_wdata[`BDC_EN_BIT];
			next_s.init_count = reg_wdata[`BDC_CNT_MSB:0];
			// Enabling arms the channel from the values written earlier.
			if (reg_wdata[`BDC_EN_BIT] && !s.en) begin
				next_s.cur_count = s.init_count;
				next_s.cur_dest = s.init_dest;
				next_s.cur_src = s.init_src;
				next_s.run = 1'b0;
			end
		end
		if (start && s.en) begin
			next_s.run = 1'b1;
		end

		case (s.state)
			bdc_pkg::BDC_IDLE: begin
				// Reserved direction or empty count never starts a unit.
				if (s.en && !cancel && (s.cur_count != `BDC_RST_CNT)
					&& (s.dest_dir != `BDC_DIR_RESERVED)
					&& (s.run || (s.req_pend
					&& s.gate == `BDC_GATE_OPEN))) begin
					next_s.state = bdc_pkg::BDC_BUSY;
					next_s.xfer_valid = 1'b1;
					if (!s.run) begin
						next_s.req_pend = req_edge;
					end
				end
			end
			bdc_pkg::BDC_BUSY: begin
				if (xfer_done) begin
					next_s.xfer_valid = 1'b0;
					next_s.state = bdc_pkg::BDC_IDLE;
					next_s.cur_count = st.next_count;
					next_s.cur_dest = st.next_dest;
					next_s.cur_src = st.next_src;
					if (s.int_mode == `BDC_INT_UNIT) begin
						next_s.irq = 1'b1;
					end
					if (st.terminal) begin
						next_s.run = 1'b0;
						if (s.int_mode == `BDC_INT_TC) begin
							next_s.irq = 1'b1;
						end
						if (s.auto_reload) begin
							next_s.cur_count = s.init_count;
							next_s.cur_dest = s.init_dest;
							next_s.cur_src = s.init_src;
						end else begin
							next_s.en = 1'b0;
						end
					end
				end
			end
			default: begin
				next_s.state = bdc_pkg::BDC_IDLE;
				next_s.xfer_valid = 1'b0;
			end
		endcase

		// Cancel wins over state, enable and requests; a unit finishing now still updates count, addresses and irq.
		if (cancel) begin
			next_s.state = bdc_pkg::BDC_IDLE;
			next_s.xfer_valid = 1'b0;
			next_s.en = 1'b0;
			next_s.run = 1'b0;
			next_s.req_pend = 1'b0;
		end

		if (reg_read) begin
			case (reg_addr)
				`BDC_OFF_CTRL: next_s.rdata = {26'h0000000, status,
					s.gate, 2'h0};
				`BDC_OFF_ISRC: next_s.rdata = {s.size, s.src_step, s.init_src};
				`BDC_OFF_IDES: next_s.rdata = {s.dest_dir, s.dest_step,
					s.init_dest};
				`BDC_OFF_INITIAL_COUNT: next_s.rdata = cnt_upper
					| {12'h000, s.init_count};
				`BDC_OFF_CSRC: next_s.rdata = {s.size, s.src_step, s.cur_src};
				`BDC_OFF_CDES: next_s.rdata = {s.dest_dir, s.dest_step,
					s.cur_dest};
				`BDC_OFF_CURRENT_COUNT: next_s.rdata = cnt_upper
					| {12'h000, s.cur_count};
				default: next_s.rdata = 32'h00000000;
			endcase
		end
	end

	// -------------------------------------------------------------------
	// State register
	// -------------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (reset) begin
			s <= '0;
			s.state <= bdc_pkg::BDC_IDLE;
			s.init_dest <= `BDC_RST_ADDR;
			s.cur_dest <= `BDC_RST_ADDR;
			s.init_count <= `BDC_RST_CNT;
			s.cur_count <= `BDC_RST_CNT;
			s.dest_dir <= `BDC_RST_FIELD2;
		end else begin
			s <= next_s;
		end
	end

	assign reg_rdata = s.rdata;
	assign xfer_valid = s.xfer_valid;
	assign xfer_dir = s.dest_dir;
	assign xfer_size = s.size;
	assign xfer_src = s.cur_src;
	assign xfer_dest = s.cur_dest;
	assign irq_pulse = s.irq;
endmodule // bdc_channel
`default_nettype wire

// ===== bench/bdc_far_model.sv
`default_nettype none
module bdc_far_model (
	input wire logic clock,
	input wire logic reset,
	input wire logic xfer_valid,
	input wire logic [3:0] lat,
	output logic xfer_done
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] wait_n;
	// Memory or peripheral side finishes each unit after lat+1 idle cycles.
	always_ff @(posedge clock) begin
		xfer_done <= 1'b0;
		if (reset || !xfer_valid || xfer_done) begin
			wait_n <= 4'h0;
		end else if (wait_n == lat) begin
			xfer_done <= 1'b1;
		end else begin
			wait_n <= wait_n + 4'h1;
		end
	end
endmodule // bdc_far_model
`default_nettype wire

// ===== bench/bdc_channel_props.sv
`default_nettype none
module bdc_channel_props (
	input wire logic clock,
	input wire logic reset,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [31:0] reg_rdata,
	input wire logic [3:0] dma_req,
	input wire logic xfer_valid,
	input wire logic xfer_done,
	input wire logic [1:0] xfer_dir,
	input wire logic [1:0] xfer_size,
	input wire logic [27:0] xfer_src,
	input wire logic [27:0] xfer_dest,
	input wire logic irq_pulse
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	logic cancel_w;
	logic unit_end;
	assign cancel_w = reg_write && reg_addr == 8'h00 && reg_wdata[1:0] == 2'h3;
	assign unit_end = xfer_valid && xfer_done;
	a_dir_legal:
	assert property (xfer_valid |-> xfer_dir != 2'h0) else $error("bad dir");
	a_unit_ends:
	assert property (unit_end |=> !xfer_valid) else $error("unit stuck");
	a_cancel_stops:
	assert property (cancel_w |=> !xfer_valid [*4]) else $error("no abort");
	a_dest_hold:
	assert property (xfer_valid && !xfer_done |=> $stable(xfer_dest))
		else $error("dest moved");
	a_size_hold:
	assert property (xfer_valid && !xfer_done |=> $stable(xfer_size))
		else $error("size moved");
	a_irq_cause:
	assert property (irq_pulse |-> $past(unit_end)) else $error("stray irq");
	a_irq_single:
	assert property (irq_pulse |=> !irq_pulse) else $error("long irq");
	a_cmd_reads_zero:
	assert property (reg_read && reg_addr == 8'h00 |=> reg_rdata[1:0] == 2'h0)
		else $error("cmd not cleared");
	a_fixed_modes:
	assert property (reg_read && reg_addr == 8'h18 |=> reg_rdata[29:24] == 6'h04)
		else $error("fixed modes wrong");
	c_unit: cover property (unit_end);
	c_irq: cover property (irq_pulse);
	c_cancel: cover property (cancel_w && xfer_valid);
endmodule // bdc_channel_props
bind bdc_channel bdc_channel_props i_bdc_channel_props (.clock(clock),
	.reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
	.dma_req(dma_req), .xfer_valid(xfer_valid), .xfer_done(xfer_done),
	.xfer_dir(xfer_dir), .xfer_size(xfer_size), .xfer_src(xfer_src),
	.xfer_dest(xfer_dest), .irq_pulse(irq_pulse));
`default_nettype wire

// ===== bench/test_bridge_dma_dest_count.sv
`default_nettype none
module test_bridge_dma_dest_count;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock, reset, reg_write, reg_read, xfer_valid, xfer_done, irq_pulse;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, got;
	logic [3:0] dma_req, lat;
	logic [1:0] xfer_dir, xfer_size;
	logic [27:0] xfer_src, xfer_dest;
	int n_mismatch, cmp_count, n_units, n_irq, cyc;
	bdc_channel i_bdc_channel (.clock(clock), .reset(reset),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .dma_req(dma_req),
		.xfer_valid(xfer_valid), .xfer_done(xfer_done), .xfer_dir(xfer_dir),
		.xfer_size(xfer_size), .xfer_src(xfer_src), .xfer_dest(xfer_dest),
		.irq_pulse(irq_pulse));
	bdc_far_model i_bdc_far_model (.clock(clock), .reset(reset),
		.xfer_valid(xfer_valid), .lat(lat), .xfer_done(xfer_done));
	// ----------------------------------------------------------------
	// Bus tasks and checks
	// ----------------------------------------------------------------
	task automatic chk(string nm, logic [31:0] exp, logic [31:0] seen);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 got = reg_rdata;
	endtask
	task automatic wait_units(int n);
		for (int i = 0; i < 300 && n_units < n; i++) @(posedge clock);
		chk("units", n, n_units);
	endtask
	task automatic pulse();
		@(posedge clock);
		dma_req <= 4'h2;
		repeat (3) @(posedge clock);
		dma_req <= 4'h0;
	endtask
	task automatic finish_test();
		$display("mismatches %0d compares %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	always @(posedge clock) begin
		n_units += int'(xfer_valid && xfer_done);
		n_irq += int'(irq_pulse);
		if (++cyc == 5000) begin
			n_mismatch++;
			finish_test();
		end
	end
	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		reset = 1'b1;
		reg_write = 1'b0;
		reg_read = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h00000000;
		dma_req = 4'h0;
		lat = 4'h2;
		repeat (3) @(posedge clock);
		reset <= 1'b0;
		rd(8'h14); chk("cdes", 32'h0, got);
		rd(8'h18); chk("current_count", 32'h04000000, got);
		rd(8'h40); chk("unmapped", 32'h0, got);
		$display("reset test done");
		wr(8'h04, 32'h90000100);
		wr(8'h08, 32'h50001000);
		wr(8'h0c, 32'h40800008);
		wr(8'h0c, 32'h40900008);
		wr(8'h00, 32'h1);
		wait_units(2);
		chk("dir", 2'h1, xfer_dir);
		rd(8'h14); chk("cdes", 28'h1008, got[27:0]);
		rd(8'h18); chk("current_count", 32'h44800000, got);
		chk("irq", 2, n_irq);
		rd(8'h10);
		chk("csrc", 32'h90000108, got);
		rd(8'h08);
		chk("ides", 32'h50001000, got);
		chk("src", 28'h108, xfer_src);
		chk("size", 2'h2, xfer_size);
		chk("dest", 28'h1008, xfer_dest);
		$display("word increment test done");
		lat = 4'h5;
		wr(8'h04, 32'h0);
		wr(8'h08, 32'ha0000200);
		wr(8'h0c, 32'h40e00002);
		wr(8'h0c, 32'h40f00002);
		pulse();
		wait_units(3);
		rd(8'h14); chk("cdes", 28'h1ff, got[27:0]);
		rd(8'h18); chk("current_count", 20'h1, got[19:0]);
		pulse();
		wait_units(4);
		rd(8'h14); chk("cdes", 28'h200, got[27:0]);
		rd(8'h18); chk("current_count", 32'h44f00002, got);
		chk("irq", 3, n_irq);
		repeat (20) @(posedge clock);
		chk("units", 4, n_units);
		$display("byte reload test done");
		wr(8'h00, 32'h4);
		pulse();
		repeat (20) @(posedge clock);
		chk("units", 4, n_units);
		wr(8'h00, 32'h0);
		wait_units(5);
		lat = 4'hc;
		pulse();
		for (int i = 0; i < 50 && !xfer_valid; i++) @(posedge clock);
		wr(8'h00, 32'h3);
		rd(8'h18); chk("current_count", 32'h44e00001, got);
		wr(8'h00, 32'h1);
		repeat (20) @(posedge clock);
		chk("units", 5, n_units);
		rd(8'h00); chk("cmd", 2'h0, got[1:0]);
		$display("gate cancel test done");
		wr(8'h04, 32'h50000040);
		wr(8'h08, 32'hf0000300);
		wr(8'h0c, 32'h80000004);
		wr(8'h0c, 32'h80100004);
		wr(8'h00, 32'h1);
		wait_units(7);
		rd(8'h10);
		chk("csrc", 32'h50000044, got);
		rd(8'h14);
		chk("cdes", 32'hf0000300, got);
		rd(8'h18);
		chk("current_count", 32'h84000000, got);
		chk("dest", 28'h300, xfer_dest);
		chk("src", 28'h44, xfer_src);
		chk("size", 2'h1, xfer_size);
		chk("dir", 2'h3, xfer_dir);
		chk("irq", 3, n_irq);
		$display("half fixed test done");
		finish_test();
	end
endmodule // test_bridge_dma_dest_count
`default_nettype wire
